// ### design/pci_config_id_cmd_status.sv
// Identity and command/status configuration words of the PCI interface.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module pci_config_id_cmd_status
(
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire cfg_regs_pkg::cfg_req_t   req,
  input  wire cfg_regs_pkg::bus_events_t events,
  output logic [31:0]                   rdata,
  output logic                          rvalid,
  output logic                          req_abort,
  output logic                          master_enable,
  output logic                          memory_enable,
  output logic                          bus_detached,
  output logic                          serr_drive,
  output logic                          fatal_error
);
  import cfg_regs_pkg::*;

  cfg_state_t state;
  cfg_state_t next_state;
  logic       legal_be;
  logic [31:0] lane_mask;
  logic [15:0] set_bits;

  function automatic logic legal_lanes(input logic [3:0] be);
    case (be)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: legal_lanes = 1'b1;
      default: legal_lanes = 1'b0;
    endcase
  endfunction : legal_lanes

  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lanes

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    legal_be   = legal_lanes(req.byte_lane_enables);
    lane_mask  = lanes(req.byte_lane_enables);
    set_bits   = 16'h0000;
    next_state.rvalid = 1'b0;
    next_state.serr   = 1'b0;
    // Status event capture; the set is applied after the clear below.
    set_bits[BIT_DET_PAR - 16] = events.addr_parity_err
                               | events.data_parity_err;
    set_bits[BIT_SIG_SERR - 16] = state.serr;
    set_bits[BIT_RX_MABORT - 16] = events.master_abort;
    set_bits[BIT_RX_TABORT - 16] = events.target_abort_rx;
    set_bits[BIT_DATA_PAR - 16] = events.perr_seen & events.master_active
                                & state.command[BIT_PAR_RESP];
    set_bits[BIT_TGT_ABORT - 16] = events.target_abort_tx
                                 | (req.valid & req.write & ~legal_be);
    next_state.serr = events.addr_parity_err
                    & state.command[BIT_SERR_EN];
    if (req.valid && events.addr_parity_err == 1'b0)
    begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = ZERO_WORD;
      if (!req.write)
      begin
        case (req.offset)
          OFF_IDENTITY:
            next_state.rdata = {DEVICE_ID_DEF, MAKER_ID_DEF};
          OFF_CMD_STATUS:
            next_state.rdata = {state.status | STS_FIXED,
                                state.command};
          default: next_state.rdata = ZERO_WORD;
        endcase
      end
      else if (legal_be && req.offset == OFF_CMD_STATUS)
      begin
        // Identity offset falls through here untouched.
        next_state.command = (state.command
                              & ~(CMD_WRITABLE & lane_mask[15:0]))
                           | (req.wdata[15:0] & CMD_WRITABLE
                              & lane_mask[15:0]);
        next_state.status = state.status
                          & ~(req.wdata[31:16] & STS_W1C
                              & lane_mask[31:16]);
      end
    end
    // Set wins over clear so a coincident event survives.
    next_state.status = (next_state.status | set_bits) & STS_W1C;
    next_state.fatal  = state.fatal | ((events.addr_parity_err
                      | events.data_parity_err)
                      & state.command[BIT_PAR_RESP]);
  end

  // Only the hardware reset pin restores defaults; no soft reset reaches here.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state.command <= CMD_STATUS_DEF[15:0];
      state.status  <= 16'h0000;
      state.rdata   <= ZERO_WORD;
      state.rvalid  <= 1'b0;
      state.serr    <= 1'b0;
      state.fatal   <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign rdata         = state.rdata;
  assign rvalid        = state.rvalid;
  assign req_abort     = req.valid & req.write & ~legal_be;
  assign master_enable = state.command[BIT_MASTER_EN];
  assign memory_enable = state.command[BIT_MEM_EN];
  assign bus_detached  = (state.command & CMD_WRITABLE) == 16'h0000;
  assign serr_drive    = state.serr;
  assign fatal_error   = state.fatal;

  //////////////////////////////////////////////////////////////////////////////
  property p_id_read;
    @(posedge mclk) disable iff (reset)
    (req.valid && !req.write && req.offset == OFF_IDENTITY
     && !events.addr_parity_err)
    |=> rvalid && rdata == {DEVICE_ID_DEF, MAKER_ID_DEF};
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identity wrong");

  property p_id_ro;
    @(posedge mclk) disable iff (reset)
    (req.valid && req.write && req.offset == OFF_IDENTITY
     && !events.addr_parity_err)
    |=> $stable(state.command) ##0 (rdata == ZERO_WORD);
  endproperty
  a_id_ro: assert property (p_id_ro)
    else $error("id write hit");

  property p_cmd_mask;
    @(posedge mclk) disable iff (reset)
    (state.command & ~CMD_WRITABLE) == 16'h0000;
  endproperty
  a_cmd_mask: assert property (p_cmd_mask)
    else $error("reserved command bit set");

  property p_cmd_write;
    @(posedge mclk) disable iff (reset)
    (req.valid && req.write && req.offset == OFF_CMD_STATUS
     && req.byte_lane_enables == 4'hF && !events.addr_parity_err)
    |=> state.command == ($past(req.wdata[15:0]) & CMD_WRITABLE);
  endproperty
  a_cmd_write: assert property (p_cmd_write)
    else $error("command write lost");

  property p_detach;
    @(posedge mclk) disable iff (reset)
    (master_enable || memory_enable) |-> !bus_detached;
  endproperty
  a_detach: assert property (p_detach)
    else $error("detached while enabled");

  property p_clear;
    @(posedge mclk) disable iff (reset)
    (req.valid && req.write && req.offset == OFF_CMD_STATUS
     && req.byte_lane_enables == 4'hF && !events.addr_parity_err
     && req.wdata[BIT_RX_MABORT] && !events.master_abort)
    |=> !state.status[BIT_RX_MABORT - 16];
  endproperty
  a_clear: assert property (p_clear)
    else $error("write one did not clear");

  property p_hold;
    @(posedge mclk) disable iff (reset)
    (state.status[BIT_RX_TABORT - 16] && !(req.valid && req.write))
    |=> state.status[BIT_RX_TABORT - 16];
  endproperty
  a_hold: assert property (p_hold)
    else $error("status bit lost");

  property p_det_par;
    @(posedge mclk) disable iff (reset)
    events.data_parity_err |=> state.status[BIT_DET_PAR - 16];
  endproperty
  a_det_par: assert property (p_det_par)
    else $error("parity lost");

  property p_serr;
    @(posedge mclk) disable iff (reset)
    (events.addr_parity_err && state.command[BIT_SERR_EN])
    |=> serr_drive ##1 state.status[BIT_SIG_SERR - 16];
  endproperty
  a_serr: assert property (p_serr)
    else $error("serr missing");

  property p_sig_serr;
    @(posedge mclk) disable iff (reset)
    serr_drive |=> state.status[BIT_SIG_SERR - 16];
  endproperty
  a_sig_serr: assert property (p_sig_serr)
    else $error("system error not recorded");

  property p_sig_serr_src;
    @(posedge mclk) disable iff (reset)
    $rose(state.status[BIT_SIG_SERR - 16]) |-> $past(serr_drive);
  endproperty
  a_sig_serr_src: assert property (p_sig_serr_src)
    else $error("system error bit without drive");

  property p_abort_set;
    @(posedge mclk) disable iff (reset)
    events.master_abort |=> state.status[BIT_RX_MABORT - 16];
  endproperty
  a_abort_set: assert property (p_abort_set)
    else $error("abort lost");

  property p_rx_tabort;
    @(posedge mclk) disable iff (reset)
    events.target_abort_rx |=> state.status[BIT_RX_TABORT - 16];
  endproperty
  a_rx_tabort: assert property (p_rx_tabort)
    else $error("received target abort lost");

  property p_illegal_be;
    @(posedge mclk) disable iff (reset)
    (req.valid && req.write && req.byte_lane_enables == 4'h5)
    |-> req_abort ##1 state.status[BIT_TGT_ABORT - 16];
  endproperty
  a_illegal_be: assert property (p_illegal_be)
    else $error("no abort");

  property p_tx_tabort;
    @(posedge mclk) disable iff (reset)
    events.target_abort_tx |=> state.status[BIT_TGT_ABORT - 16];
  endproperty
  a_tx_tabort: assert property (p_tx_tabort)
    else $error("signalled target abort lost");

  property p_ill_no_store;
    @(posedge mclk) disable iff (reset)
    req_abort |=> $stable(state.command);
  endproperty
  a_ill_no_store: assert property (p_ill_no_store)
    else $error("aborted write stored");

  property p_fixed_bits;
    @(posedge mclk) disable iff (reset)
    (rvalid && $past(req.offset) == OFF_CMD_STATUS && !$past(req.write))
    |-> rdata[26:25] == 2'b01 && rdata[21] == 1'b0;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("fixed bits");

  property p_data_par;
    @(posedge mclk) disable iff (reset)
    (!$past(state.status[BIT_DATA_PAR - 16])
     && state.status[BIT_DATA_PAR - 16])
    |-> $past(state.command[BIT_PAR_RESP] && events.master_active
              && events.perr_seen);
  endproperty
  a_data_par: assert property (p_data_par)
    else $error("bit 24 bad");

  property p_no_serr;
    @(posedge mclk) disable iff (reset)
    !state.command[BIT_SERR_EN] |=> !serr_drive;
  endproperty
  a_no_serr: assert property (p_no_serr)
    else $error("serr unasked");

  property p_fatal_set;
    @(posedge mclk) disable iff (reset)
    ((events.addr_parity_err || events.data_parity_err)
     && state.command[BIT_PAR_RESP]) |=> fatal_error;
  endproperty
  a_fatal_set: assert property (p_fatal_set)
    else $error("fatal error missing");

  property p_fatal_sticky;
    @(posedge mclk) disable iff (reset)
    fatal_error |=> fatal_error;
  endproperty
  a_fatal_sticky: assert property (p_fatal_sticky)
    else $error("fatal error dropped");

  property p_fatal_off;
    @(posedge mclk) disable iff (reset)
    (!fatal_error && !state.command[BIT_PAR_RESP]) |=> !fatal_error;
  endproperty
  a_fatal_off: assert property (p_fatal_off)
    else $error("fatal error while parity ignored");

  property p_rvalid_follows;
    @(posedge mclk) disable iff (reset)
    (req.valid && !events.addr_parity_err) |=> rvalid;
  endproperty
  a_rvalid_follows: assert property (p_rvalid_follows)
    else $error("request not answered");

  property p_drop;
    @(posedge mclk) disable iff (reset)
    (!req.valid || events.addr_parity_err) |=> !rvalid;
  endproperty
  a_drop: assert property (p_drop)
    else $error("answer without request");

  property p_reserved_rd;
    @(posedge mclk) disable iff (reset)
    (req.valid && !req.write && !events.addr_parity_err
     && req.offset != OFF_IDENTITY && req.offset != OFF_CMD_STATUS)
    |=> rdata == ZERO_WORD;
  endproperty
  a_reserved_rd: assert property (p_reserved_rd)
    else $error("reserved read not zero");

  property p_set_wins;
    @(posedge mclk) disable iff (reset)
    (events.master_abort && req.valid && req.write
     && req.wdata[BIT_RX_MABORT]) |=> state.status[BIT_RX_MABORT - 16];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost to clear");

  c_master: cover property (@(posedge mclk) disable iff (reset)
    $rose(master_enable));
  c_serr: cover property (@(posedge mclk) disable iff (reset)
    $rose(serr_drive));
  c_set_wins: cover property (@(posedge mclk) disable iff (reset)
    events.master_abort && req.valid && req.write);
  c_clear: cover property (@(posedge mclk) disable iff (reset)
    $fell(state.status[BIT_RX_TABORT - 16]));
  c_fatal: cover property (@(posedge mclk) disable iff (reset)
    $rose(fatal_error));
endmodule : pci_config_id_cmd_status
`default_nettype wire

// ### include/cfg_regs_pkg.sv
// Package with offsets, fields, defaults and carrier types of the config words.
`default_nettype none
package cfg_regs_pkg;
  localparam logic [7:0]  OFF_IDENTITY   = 8'h00;
  localparam logic [7:0]  OFF_CMD_STATUS = 8'h04;
  localparam logic [15:0] DEVICE_ID_DEF  = 16'h0A5A; // Arbitrary value.
  localparam logic [15:0] MAKER_ID_DEF   = 16'h1234; // Arbitrary value.
  localparam int BIT_MEM_EN    = 1;
  localparam int BIT_MASTER_EN = 2;
  localparam int BIT_PAR_RESP  = 6;
  localparam int BIT_SERR_EN   = 8;
  localparam int BIT_DATA_PAR  = 24;
  localparam int BIT_TGT_ABORT = 27;
  localparam int BIT_RX_TABORT = 28;
  localparam int BIT_RX_MABORT = 29;
  localparam int BIT_SIG_SERR  = 30;
  localparam int BIT_DET_PAR   = 31;
  localparam logic [15:0] CMD_WRITABLE   = 16'h0146;
  localparam logic [15:0] STS_W1C        = 16'hF900;
  localparam logic [15:0] STS_FIXED      = 16'h0200;
  localparam logic [31:0] CMD_STATUS_DEF = 32'h0200_0000;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  offset;
    logic [3:0]  byte_lane_enables;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic addr_parity_err;
    logic data_parity_err;
    logic perr_seen;
    logic master_active;
    logic master_abort;
    logic target_abort_rx;
    logic target_abort_tx;
  } bus_events_t;

  typedef struct packed {
    logic [15:0] command;
    logic [15:0] status;
    logic [31:0] rdata;
    logic        rvalid;
    logic        serr;
    logic        fatal;
  } cfg_state_t;
endpackage : cfg_regs_pkg
`default_nettype wire

// ### sim/cfg_host_model.sv
// Host model issuing configuration cycles and bus event pulses.
`default_nettype none
module cfg_host_model
(
  input  wire logic                      mclk,
  input  wire logic                      req_abort,
  output var  cfg_regs_pkg::cfg_req_t    req,
  output var  cfg_regs_pkg::bus_events_t ev
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_regs_pkg::*;
  logic ab;
  initial
  begin
    req = '0;
    ev  = '0;
    ab  = 1'b0;
  end
  // One-cycle request; a released bus shows inverted fields, not stale ones.
  task automatic cfg(input logic w, input logic [7:0] o,
                     input logic [3:0] be, input logic [31:0] d);
    @(posedge mclk) #1;
    req = '{1'b1, w, o, be, d};
    #2 ab = req_abort;
    @(posedge mclk) #1;
    req = '{1'b0, ~w, ~o, ~be, ~d};
  endtask : cfg
  task automatic pulse(input bus_events_t e);
    @(posedge mclk) #1;
    ev = e;
    @(posedge mclk) #1;
    ev = '0;
  endtask : pulse
endmodule : cfg_host_model
`default_nettype wire

// ### sim/test_pci_config_id_cmd_status.sv
// Self-checking bench of the identity and command/status words.
`default_nettype none
module test_pci_config_id_cmd_status;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_regs_pkg::*;
  logic mclk, reset, req_abort, master_enable, memory_enable;
  logic bus_detached, serr_drive, fatal_error, rvalid;
  logic [31:0] rdata, d;
  logic [15:0] cmd;
  logic [3:0]  be;
  logic [3:0]  legal [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  cfg_req_t    req;
  bus_events_t ev;
  int bad_count = 0;
  int tests_run = 0;
  pci_config_id_cmd_status u_dut (.mclk(mclk), .reset(reset), .req(req),
    .events(ev), .rdata(rdata), .rvalid(rvalid), .req_abort(req_abort),
    .master_enable(master_enable), .memory_enable(memory_enable),
    .bus_detached(bus_detached), .serr_drive(serr_drive),
    .fatal_error(fatal_error));
  cfg_host_model u_host (.mclk(mclk), .req_abort(req_abort), .req(req),
    .ev(ev));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nc(logic [15:0] c, logic [3:0] b,
                                     logic [31:0] v);
    logic [15:0] m;
    m = {{8{b[1]}}, {8{b[0]}}} & CMD_WRITABLE;
    return (c & ~m) | (v[15:0] & m);
  endfunction : nc
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [7:0] o);
    u_host.cfg(1'b0, o, 4'hF, 32'h0000_0000);
    chk("rvalid", rvalid, 32'h1);
  endtask : rd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #40000;
    bad_count++;
    end_sim();
  end
  initial
  begin
    reset = 1'b1;
    d = $urandom(32);
    repeat (10) @(posedge mclk);
    #1 reset = 1'b0;
    u_host.cfg(1'b0, OFF_IDENTITY, 4'h5, 32'h0000_0000);
    chk("rd_abort", u_host.ab, 32'h0);
    chk("id", rdata, {DEVICE_ID_DEF, MAKER_ID_DEF});
    u_host.cfg(1'b1, OFF_IDENTITY, 4'hF, 32'hFFFF_FFFF);
    rd(OFF_IDENTITY);
    chk("id_ro", rdata, {DEVICE_ID_DEF, MAKER_ID_DEF});
    rd(OFF_CMD_STATUS);
    chk("cs_def", rdata, CMD_STATUS_DEF);
    chk("detached", bus_detached, 32'h1);
    cmd = 16'h0000;
    // Random writes use only legal enables so the lane merge is checked.
    repeat (20)
    begin
      d = $urandom & 32'h0000_FFFF;
      be = legal[$urandom % 7];
      u_host.cfg(1'b1, OFF_CMD_STATUS, be, d);
      chk("wr_abort", u_host.ab, 32'h0);
      cmd = nc(cmd, be, d);
      rd(OFF_CMD_STATUS);
      chk("cs", rdata, {16'h0200, cmd});
      chk("mem_en", memory_enable, cmd[1]);
      chk("mst_en", master_enable, cmd[2]);
      chk("detach", bus_detached, (cmd & CMD_WRITABLE) == 0);
    end
    u_host.cfg(1'b1, OFF_CMD_STATUS, 4'hF, 32'h0000_0004);
    cmd = 16'h0004;
    u_host.pulse(7'h38); // Data parity, perr seen, master active.
    chk("fatal0", fatal_error, 32'h0);
    rd(OFF_CMD_STATUS);
    chk("par", rdata & 32'h8100_0000, 32'h8000_0000);
    u_host.cfg(1'b1, OFF_CMD_STATUS, 4'hF, 32'h0000_0146);
    cmd = 16'h0146;
    u_host.pulse(7'h38);
    chk("fatal1", fatal_error, 32'h1);
    u_host.pulse(7'h40); // Address parity error.
    chk("serr", serr_drive, 32'h1);
    u_host.pulse(7'h07); // Master abort, received and signalled aborts.
    u_host.cfg(1'b1, OFF_CMD_STATUS, 4'h5, 32'h0000_0000);
    chk("ill_abort", u_host.ab, 32'h1);
    rd(OFF_CMD_STATUS);
    chk("sts_all", rdata, {16'hFB00, cmd});
    u_host.cfg(1'b1, OFF_CMD_STATUS, 4'hF, 32'h8800_0146);
    rd(OFF_CMD_STATUS);
    chk("w1c", rdata, {16'h7300, cmd});
    // A master abort lands in the very cycle its bit is written clear.
    fork
      u_host.pulse(7'h04);
      u_host.cfg(1'b1, OFF_CMD_STATUS, 4'hF, 32'h2000_0146);
    join
    rd(OFF_CMD_STATUS);
    chk("set_wins", rdata, {16'h7300, cmd});
    u_host.cfg(1'b1, 8'h08, 4'hF, $urandom);
    rd(8'h08);
    chk("reserved", rdata, ZERO_WORD);
    @(posedge mclk) #1 reset = 1'b1;
    @(posedge mclk) #1 reset = 1'b0;
    rd(OFF_CMD_STATUS);
    chk("hw_reset", rdata, CMD_STATUS_DEF);
    chk("fatal_rst", fatal_error, 32'h0);
    end_sim();
  end
endmodule : test_pci_config_id_cmd_status
`default_nettype wire
